// ===== dtio_terminal_io.sv
// drive control terminal logic: three-wire run, fault action, output routing
//
// Operation
// - mode one: no button change keeps direction
// - mode two: run button release changes nothing
// - mode two: direction level, 0 forward, 1 reverse
// - external fault action: coast, emergency, decelerate, continue
// - six outputs each select function code 0-41
// - relays two to four need expansion board
// - code 0 output does nothing
// - code 1: powered, enabled, no fault
// - codes 2-4: running, forward, reverse
// - code 5: dc braking active
// - codes 6-7: zero frequency, stopped or running
// - code 8: torque limit under speed control
// - codes 9-10: frequency level detections
// - code 11: output within arrival width
// - codes 12-13: set at upper / lower limit
// - code 14: wobble exceeds limits, when enabled
// - six-bit mask inverts individual outputs
`timescale 1ns/100ps
module dtio_terminal_io #(
  parameter int unsigned FREQ_W = 16
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              reset,
  // terminal pins, high while the contact is closed
  input  wire logic              stop_button,
  input  wire logic              forward_or_run_button,
  input  wire logic              reverse_button,
  input  wire logic              direction_switch,
  input  wire logic              ext_fault_pin,
  // configuration
  input  wire logic [1:0]        run_wiring_mode_sel,
  input  wire logic [1:0]        ext_fault_action_sel,
  input  wire logic [5:0]        oc_out_a_function_sel,
  input  wire logic [5:0]        oc_out_b_function_sel,
  input  wire logic [5:0]        relay_1_function_sel,
  input  wire logic [5:0]        relay_2_function_sel,
  input  wire logic [5:0]        relay_3_function_sel,
  input  wire logic [5:0]        relay_4_function_sel,
  input  wire logic [5:0]        output_polarity_mask,
  input  wire logic              expansion_board_fitted,
  input  wire logic              wobble_function_enable,
  // drive state
  input  wire logic              drive_powered,
  input  wire logic              enable_input_used,
  input  wire logic              enable_input,
  input  wire logic              drive_fault,
  input  wire logic              drive_running,
  input  wire logic              drive_reverse,
  input  wire logic              dc_braking,
  input  wire logic              torque_limit_active,
  input  wire logic              freq_level_detect_1,
  input  wire logic              freq_level_detect_2,
  // frequencies
  input  wire logic [FREQ_W-1:0] output_freq,
  input  wire logic [FREQ_W-1:0] set_freq,
  input  wire logic [FREQ_W-1:0] upper_limit_freq,
  input  wire logic [FREQ_W-1:0] lower_limit_freq,
  input  wire logic [FREQ_W-1:0] zero_freq_level,
  input  wire logic [FREQ_W-1:0] arrival_detect_width,
  input  wire logic [FREQ_W-1:0] wobble_centre_freq,
  input  wire logic [FREQ_W-1:0] wobble_amplitude,
  // run commands
  output logic                   run_cmd_reg,
  output logic                   reverse_cmd_reg,
  // fault action commands
  output logic                   ext_fault_reg,
  output logic                   coast_stop_reg,
  output logic                   emergency_stop_reg,
  output logic                   decel_stop_reg,
  // status outputs
  output logic                   open_collector_out_a,
  output logic                   open_collector_out_b,
  output logic                   relay_out_1,
  output logic                   relay_out_2,
  output logic                   relay_out_3,
  output logic                   relay_out_4
);

  // frequency words beyond this cannot be summed without overflow logic
  if (FREQ_W < 4 || FREQ_W > 30) begin : g_bad_width
    $error("FREQ_W must lie between 4 and 30");
  end

  // a at most b
  function automatic logic at_most(input logic [FREQ_W-1:0] a,
                                   input logic [FREQ_W-1:0] b);
    at_most = (a <= b);
  endfunction

  // distance of a from b no more than w
  function automatic logic in_band(input logic [FREQ_W-1:0] a,
                                   input logic [FREQ_W-1:0] b,
                                   input logic [FREQ_W-1:0] w);
    logic [FREQ_W-1:0] diff;
    diff = '0;
    diff = (a >= b) ? (a - b) : (b - a);
    in_band = at_most(diff, w);
  endfunction

  // synchronised pin levels
  logic [4:0] pins_sync;
  logic       stop_s;
  logic       fwd_s;
  logic       rev_s;
  logic       dir_s;
  logic       fault_s;

  // pins come from the terminal block, asynchronous to sys_clk
  dtio_sync #(
    .WIDTH (5)
  ) u_sync (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .async_in ({ext_fault_pin, direction_switch, reverse_button,
                forward_or_run_button, stop_button}),
    .sync_out (pins_sync)
  );

  assign stop_s  = pins_sync[0];
  assign fwd_s   = pins_sync[1];
  assign rev_s   = pins_sync[2];
  assign dir_s   = pins_sync[3];
  assign fault_s = pins_sync[4];

  // edge detection on synchronised levels
  logic fwd_prev_reg;
  logic rev_prev_reg;
  logic fwd_rise;
  logic rev_rise;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fwd_prev_reg <= 1'b0;
      rev_prev_reg <= 1'b0;
    end else begin
      fwd_prev_reg <= fwd_s;
      rev_prev_reg <= rev_s;
    end
  end

  assign fwd_rise = fwd_s && !fwd_prev_reg;
  assign rev_rise = rev_s && !rev_prev_reg;

  // stop by an open normally-closed contact; a broken wire also stops
  logic stop_req;
  logic fault_stop;
  logic three_wire;

  assign stop_req   = !stop_s;
  assign fault_stop = fault_s &&
                      (ext_fault_action_sel != dtio_pkg::FA_CONTINUE);
  assign three_wire = (run_wiring_mode_sel == dtio_pkg::MODE_3W_1) ||
                      (run_wiring_mode_sel == dtio_pkg::MODE_3W_2);

  // run latch and direction; a stop needs a fresh start edge afterwards
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      run_cmd_reg     <= 1'b0;
      reverse_cmd_reg <= 1'b0;
    end else begin
      case (run_wiring_mode_sel)
        dtio_pkg::MODE_3W_1: begin
          if (stop_req || fault_stop) begin
            run_cmd_reg <= 1'b0;
          end else if (fwd_rise) begin
            run_cmd_reg     <= 1'b1;
            reverse_cmd_reg <= 1'b0;
          end else if (rev_rise) begin
            run_cmd_reg     <= 1'b1;
            reverse_cmd_reg <= 1'b1;
          end else begin
            // no edge: direction is held as it is
            reverse_cmd_reg <= reverse_cmd_reg;
          end
        end
        dtio_pkg::MODE_3W_2: begin
          // only a press starts; the button's release falls through
          if (stop_req || fault_stop) begin
            run_cmd_reg <= 1'b0;
          end else if (fwd_rise) begin
            run_cmd_reg <= 1'b1;
          end
          reverse_cmd_reg <= dir_s;
        end
        default: begin
          // two-wire modes are served elsewhere
          run_cmd_reg <= 1'b0;
        end
      endcase
    end
  end

  // fault action strobes follow the synchronised fault level
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ext_fault_reg      <= 1'b0;
      coast_stop_reg     <= 1'b0;
      emergency_stop_reg <= 1'b0;
      decel_stop_reg     <= 1'b0;
    end else begin
      ext_fault_reg      <= fault_s;
      coast_stop_reg     <= fault_s && (ext_fault_action_sel == dtio_pkg::FA_COAST);
      emergency_stop_reg <= fault_s && (ext_fault_action_sel == dtio_pkg::FA_EMERG);
      decel_stop_reg     <= fault_s && (ext_fault_action_sel == dtio_pkg::FA_DECEL);
    end
  end

  // wobble band against the limits; sums carry one extra bit
  logic [FREQ_W:0] wob_top;
  logic [FREQ_W:0] wob_floor;
  logic            wobble_out;

  assign wob_top    = {1'b0, wobble_centre_freq} + {1'b0, wobble_amplitude};
  assign wob_floor  = {1'b0, lower_limit_freq} + {1'b0, wobble_amplitude};
  assign wobble_out = (wob_top > {1'b0, upper_limit_freq}) ||
                      ({1'b0, wobble_centre_freq} < wob_floor);

  // status conditions indexed by function code
  logic                             zero_freq;
  logic [dtio_pkg::NUM_FUNCS-1:0]   cond;

  assign zero_freq = at_most(output_freq, zero_freq_level);

  always_comb begin
    cond                          = '0;
    cond[dtio_pkg::FC_READY]      = drive_powered && !drive_fault &&
                                    (!enable_input_used || enable_input);
    cond[dtio_pkg::FC_RUNNING]    = drive_running;
    cond[dtio_pkg::FC_RUN_FWD]    = drive_running && !drive_reverse;
    cond[dtio_pkg::FC_RUN_REV]    = drive_running && drive_reverse;
    cond[dtio_pkg::FC_DC_BRAKE]   = dc_braking;
    cond[dtio_pkg::FC_ZERO_FREQ]  = zero_freq;
    cond[dtio_pkg::FC_ZERO_RUN]   = zero_freq && drive_running;
    cond[dtio_pkg::FC_TORQ_LIM]   = torque_limit_active;
    cond[dtio_pkg::FC_FDT_1]      = freq_level_detect_1;
    cond[dtio_pkg::FC_FDT_2]      = freq_level_detect_2;
    cond[dtio_pkg::FC_ARRIVAL]    = in_band(output_freq, set_freq,
                                            arrival_detect_width);
    cond[dtio_pkg::FC_UPPER_LIM]  = at_most(upper_limit_freq, set_freq);
    cond[dtio_pkg::FC_LOWER_LIM]  = at_most(set_freq, lower_limit_freq);
    cond[dtio_pkg::FC_WOBBLE]     = wobble_function_enable && wobble_out;
    cond[dtio_pkg::FC_DRV_FAULT]  = drive_fault;
    cond[dtio_pkg::FC_EXT_FAULT]  = fault_s;
  end

  dtio_status_if st_if ();
  assign st_if.cond = cond;

  // per-channel selection, order matches the polarity mask bits
  logic [5:0] sel_arr [dtio_pkg::NUM_OUTS];
  logic [5:0] usable;
  logic [5:0] out_arr;

  assign sel_arr[dtio_pkg::POL_OC_A]  = oc_out_a_function_sel;
  assign sel_arr[dtio_pkg::POL_OC_B]  = oc_out_b_function_sel;
  assign sel_arr[dtio_pkg::POL_RLY_1] = relay_1_function_sel;
  assign sel_arr[dtio_pkg::POL_RLY_2] = relay_2_function_sel;
  assign sel_arr[dtio_pkg::POL_RLY_3] = relay_3_function_sel;
  assign sel_arr[dtio_pkg::POL_RLY_4] = relay_4_function_sel;
  // relays two to four exist only on the expansion board
  assign usable = {{3{expansion_board_fitted}}, 3'h7};

  for (genvar i = 0; i < dtio_pkg::NUM_OUTS; i++) begin : g_out
    dtio_out_sel u_out (
      .sys_clk  (sys_clk),
      .reset    (reset),
      .func_sel (sel_arr[i]),
      .invert   (output_polarity_mask[i]),
      .usable   (usable[i]),
      .st       (st_if.dst),
      .out_reg  (out_arr[i])
    );
  end

  // terminals are driven straight from the channel flops
  assign open_collector_out_a = out_arr[dtio_pkg::POL_OC_A];
  assign open_collector_out_b = out_arr[dtio_pkg::POL_OC_B];
  assign relay_out_1          = out_arr[dtio_pkg::POL_RLY_1];
  assign relay_out_2          = out_arr[dtio_pkg::POL_RLY_2];
  assign relay_out_3          = out_arr[dtio_pkg::POL_RLY_3];
  assign relay_out_4          = out_arr[dtio_pkg::POL_RLY_4];

  // checks on the run and fault action logic
  a_mode1_hold_dir: assert property (@(posedge sys_clk) disable iff (reset)
    (run_wiring_mode_sel == dtio_pkg::MODE_3W_1) && !fwd_rise && !rev_rise
      |=> $stable(reverse_cmd_reg))
    else $error("mode one direction changed without a button edge");

  a_mode1_rev_start: assert property (@(posedge sys_clk) disable iff (reset)
    (run_wiring_mode_sel == dtio_pkg::MODE_3W_1) && !stop_req && !fault_stop &&
      !fwd_rise && rev_rise |=> run_cmd_reg && reverse_cmd_reg)
    else $error("reverse edge did not start reverse run");

  a_mode2_release: assert property (@(posedge sys_clk) disable iff (reset)
    (run_wiring_mode_sel == dtio_pkg::MODE_3W_2) && !stop_req && !fault_stop &&
      !fwd_s && fwd_prev_reg |=> $stable(run_cmd_reg))
    else $error("run button release changed the run state");

  a_mode2_dir_level: assert property (@(posedge sys_clk) disable iff (reset)
    (run_wiring_mode_sel == dtio_pkg::MODE_3W_2) |=> reverse_cmd_reg == $past(dir_s))
    else $error("direction does not follow the level input");

  a_stop_open: assert property (@(posedge sys_clk) disable iff (reset)
    three_wire && stop_req |=> !run_cmd_reg)
    else $error("open stop contact did not stop the drive");

  a_fault_action: assert property (@(posedge sys_clk) disable iff (reset)
    fault_s && (ext_fault_action_sel == dtio_pkg::FA_DECEL)
      |=> decel_stop_reg && !coast_stop_reg && !emergency_stop_reg)
    else $error("fault action strobe wrong for decelerate");

  a_fault_coast: assert property (@(posedge sys_clk) disable iff (reset)
    fault_s && (ext_fault_action_sel == dtio_pkg::FA_COAST)
      |=> coast_stop_reg && !decel_stop_reg && !emergency_stop_reg)
    else $error("fault action strobe wrong for coast");

  a_fault_continue: assert property (@(posedge sys_clk) disable iff (reset)
    three_wire && run_cmd_reg && !stop_req &&
      (ext_fault_action_sel == dtio_pkg::FA_CONTINUE) |=> run_cmd_reg)
    else $error("continue action dropped the run command");

  // checks on the output path
  a_relay_absent: assert property (@(posedge sys_clk) disable iff (reset)
    !expansion_board_fitted |=> !relay_out_2 && !relay_out_3 && !relay_out_4)
    else $error("expansion relay active without the board");

  a_run_follows: assert property (@(posedge sys_clk) disable iff (reset)
    (oc_out_a_function_sel == dtio_pkg::FC_RUNNING) && !output_polarity_mask[0]
      |=> open_collector_out_a == $past(drive_running))
    else $error("running indication not one cycle behind");

  a_pol_invert: assert property (@(posedge sys_clk) disable iff (reset)
    (relay_1_function_sel == dtio_pkg::FC_DRV_FAULT) && output_polarity_mask[2]
      |=> relay_out_1 == !$past(drive_fault))
    else $error("negative logic not applied to relay one");

  a_reset_idle: assert property (@(posedge sys_clk)
    reset |=> !open_collector_out_a && !open_collector_out_b && !relay_out_1 &&
      !run_cmd_reg)
    else $error("outputs not inactive after reset");
endmodule

// ===== dtio_pkg.sv
// shared constants for the drive terminal i/o logic
package dtio_pkg;
  // output channels and function codes
  localparam int unsigned NUM_OUTS  = 6;
  localparam int unsigned NUM_FUNCS = 42;
  localparam int unsigned FUNC_W    = 6;
  localparam logic [5:0] FC_NONE      = 6'h00;
  localparam logic [5:0] FC_READY     = 6'h01;
  localparam logic [5:0] FC_RUNNING   = 6'h02;
  localparam logic [5:0] FC_RUN_FWD   = 6'h03;
  localparam logic [5:0] FC_RUN_REV   = 6'h04;
  localparam logic [5:0] FC_DC_BRAKE  = 6'h05;
  localparam logic [5:0] FC_ZERO_FREQ = 6'h06;
  localparam logic [5:0] FC_ZERO_RUN  = 6'h07;
  localparam logic [5:0] FC_TORQ_LIM  = 6'h08;
  localparam logic [5:0] FC_FDT_1     = 6'h09;
  localparam logic [5:0] FC_FDT_2     = 6'h0a;
  localparam logic [5:0] FC_ARRIVAL   = 6'h0b;
  localparam logic [5:0] FC_UPPER_LIM = 6'h0c;
  localparam logic [5:0] FC_LOWER_LIM = 6'h0d;
  localparam logic [5:0] FC_WOBBLE    = 6'h0e;
  localparam logic [5:0] FC_DRV_FAULT = 6'h1f;
  localparam logic [5:0] FC_EXT_FAULT = 6'h20;
  // documented default function selections
  localparam logic [5:0] FUNC_DEF_OC_A  = 6'h02;
  localparam logic [5:0] FUNC_DEF_RLY_1 = 6'h1f;
  localparam logic [5:0] FUNC_DEF_OTHER = 6'h00;
  // polarity mask bit positions
  localparam int unsigned POL_OC_A  = 0;
  localparam int unsigned POL_OC_B  = 1;
  localparam int unsigned POL_RLY_1 = 2;
  localparam int unsigned POL_RLY_2 = 3;
  localparam int unsigned POL_RLY_3 = 4;
  localparam int unsigned POL_RLY_4 = 5;
  localparam logic [5:0] POL_RESET  = 6'h00;
  // run wiring modes and fault actions
  localparam logic [1:0] MODE_3W_1   = 2'h2;
  localparam logic [1:0] MODE_3W_2   = 2'h3;
  localparam logic [1:0] FA_COAST    = 2'h0;
  localparam logic [1:0] FA_EMERG    = 2'h1;
  localparam logic [1:0] FA_DECEL    = 2'h2;
  localparam logic [1:0] FA_CONTINUE = 2'h3;
  localparam logic [1:0] FA_RESET    = 2'h0;
  // pin synchroniser depth
  localparam int unsigned SYNC_STAGES = 2;
endpackage

// ===== dtio_status_if.sv
// status condition vector passed to the output selectors
`timescale 1ns/100ps
interface dtio_status_if;
  logic [dtio_pkg::NUM_FUNCS-1:0] cond;
  modport src (output cond);
  modport dst (input cond);
endinterface

// ===== dtio_sync.sv
// two-stage synchroniser for terminal pins
`timescale 1ns/100ps
module dtio_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset,
  // pins and synchronised levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// ===== dtio_out_sel.sv
// one output channel: registered function multiplexer with polarity
`timescale 1ns/100ps
module dtio_out_sel (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // configuration
  input  wire logic [5:0]  func_sel,
  input  wire logic        invert,
  input  wire logic        usable,
  // status conditions
  dtio_status_if.dst       st,
  // terminal drive
  output logic             out_reg
);
  logic idle;

  // code 0, codes beyond the table and absent hardware do nothing
  assign idle = !usable || (func_sel == dtio_pkg::FC_NONE) ||
                (func_sel >= 6'(dtio_pkg::NUM_FUNCS));

  // selected condition, inverted on request, held in a flop
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      out_reg <= 1'b0;
    end else if (idle) begin
      out_reg <= 1'b0;
    end else begin
      out_reg <= st.cond[func_sel] ^ invert;
    end
  end

  a_idle_output: assert property (@(posedge sys_clk) disable iff (reset)
    (func_sel == dtio_pkg::FC_NONE) |=> !out_reg)
    else $error("code 0 output became active");
endmodule

// ===== dtio_panel_model.sv
// push-button station and fault contact model facing the terminal pins
`timescale 1ns/100ps
module dtio_panel_model (
  // operator actions from the bench
  input  wire logic press_stop,
  input  wire logic press_fwd,
  input  wire logic press_rev,
  input  wire logic dir_level,
  input  wire logic fault_level,
  // terminal pins, high while the contact is closed
  output logic      stop_button,
  output logic      forward_or_run_button,
  output logic      reverse_button,
  output logic      direction_switch,
  output logic      ext_fault_pin
);
  // stop contact is normally closed, so pressing it opens the circuit
  assign stop_button           = ~press_stop;
  // run and reverse contacts are normally open
  assign forward_or_run_button = press_fwd;
  assign reverse_button        = press_rev;
  // latching switch and fault relay contact follow the level directly
  assign direction_switch      = dir_level;
  assign ext_fault_pin         = fault_level;
endmodule

// ===== tb_dtio_terminal_io.sv
// self-checking bench for the drive terminal i/o logic
`timescale 1ns/100ps
module tb_dtio_terminal_io;
  logic        sys_clk, reset;
  logic        p_stop, p_fwd, p_rev, p_dir, p_flt;
  wire         stop_button, forward_or_run_button, reverse_button;
  wire         direction_switch, ext_fault_pin;
  logic [1:0]  mode, act;
  logic [5:0]  sel, pol;
  logic        board, wob, pwr, en_used, en_in, dfault, running, rev, dcb, torq, fd1, fd2;
  logic [15:0] f_out, f_set, f_up, f_lo, f_zero, f_wid, f_ctr, f_amp;
  wire         run_cmd_reg, reverse_cmd_reg, ext_fault_reg;
  wire         coast_stop_reg, emergency_stop_reg, decel_stop_reg;
  wire         oc_a, oc_b, rl1, rl2, rl3, rl4;
  wire  [5:0]  outs = {rl4, rl3, rl2, rl1, oc_b, oc_a};
  int          fails, comparisons;
  logic [5:0]  codes [18] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07,
                              6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h14,
                              6'h1f, 6'h20};

  dtio_panel_model panel (.press_stop(p_stop), .press_fwd(p_fwd), .press_rev(p_rev),
    .dir_level(p_dir), .fault_level(p_flt), .stop_button(stop_button),
    .forward_or_run_button(forward_or_run_button), .reverse_button(reverse_button),
    .direction_switch(direction_switch), .ext_fault_pin(ext_fault_pin));

  dtio_terminal_io uut (.sys_clk(sys_clk), .reset(reset), .stop_button(stop_button),
    .forward_or_run_button(forward_or_run_button), .reverse_button(reverse_button),
    .direction_switch(direction_switch), .ext_fault_pin(ext_fault_pin),
    .run_wiring_mode_sel(mode), .ext_fault_action_sel(act), .oc_out_a_function_sel(sel),
    .oc_out_b_function_sel(sel), .relay_1_function_sel(sel), .relay_2_function_sel(sel),
    .relay_3_function_sel(sel), .relay_4_function_sel(sel), .output_polarity_mask(pol),
    .expansion_board_fitted(board), .wobble_function_enable(wob), .drive_powered(pwr),
    .enable_input_used(en_used), .enable_input(en_in), .drive_fault(dfault),
    .drive_running(running), .drive_reverse(rev), .dc_braking(dcb),
    .torque_limit_active(torq), .freq_level_detect_1(fd1), .freq_level_detect_2(fd2),
    .output_freq(f_out), .set_freq(f_set), .upper_limit_freq(f_up),
    .lower_limit_freq(f_lo), .zero_freq_level(f_zero), .arrival_detect_width(f_wid),
    .wobble_centre_freq(f_ctr), .wobble_amplitude(f_amp), .run_cmd_reg(run_cmd_reg),
    .reverse_cmd_reg(reverse_cmd_reg), .ext_fault_reg(ext_fault_reg),
    .coast_stop_reg(coast_stop_reg), .emergency_stop_reg(emergency_stop_reg),
    .decel_stop_reg(decel_stop_reg), .open_collector_out_a(oc_a),
    .open_collector_out_b(oc_b), .relay_out_1(rl1), .relay_out_2(rl2),
    .relay_out_3(rl3), .relay_out_4(rl4));

  // free-running 100 mhz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // one compare for every kind of bit-vector result
  task automatic chk(input string name, input logic [5:0] exp, input logic [5:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  // inputs change only just after a falling edge
  task automatic wait_n(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // single closing point for normal end and watchdog
  task automatic end_of_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // mode one: direction held while buttons rest, reverse edge flips it
  task automatic test_mode1;
    mode  = dtio_pkg::MODE_3W_1;
    p_fwd = 1'b1;
    wait_n(3);
    chk("m1 forward start", 6'h02, {4'h0, run_cmd_reg, reverse_cmd_reg});
    p_fwd = 1'b0;
    wait_n(6);
    chk("m1 idle buttons", 6'h02, {4'h0, run_cmd_reg, reverse_cmd_reg});
    p_rev = 1'b1;
    wait_n(3);
    chk("m1 reverse edge", 6'h03, {4'h0, run_cmd_reg, reverse_cmd_reg});
    p_rev  = 1'b0;
    p_stop = 1'b1;
    wait_n(3);
    chk("m1 stop", 6'h00, {5'h00, run_cmd_reg});
    p_stop = 1'b0;
    wait_n(3);
  endtask

  // mode two: run release ignored, direction follows the switch level
  task automatic test_mode2;
    mode  = dtio_pkg::MODE_3W_2;
    p_dir = 1'b0;
    p_fwd = 1'b1;
    wait_n(3);
    chk("m2 run forward", 6'h02, {4'h0, run_cmd_reg, reverse_cmd_reg});
    p_fwd = 1'b0;
    wait_n(6);
    chk("m2 run release", 6'h02, {4'h0, run_cmd_reg, reverse_cmd_reg});
    p_dir = 1'b1;
    wait_n(3);
    chk("m2 dir reverse", 6'h03, {4'h0, run_cmd_reg, reverse_cmd_reg});
    p_stop = 1'b1;
    wait_n(3);
    chk("m2 stop", 6'h00, {5'h00, run_cmd_reg});
    p_stop = 1'b0;
    wait_n(3);
  endtask

  // every fault action selection, one strobe each except continue, which raises none
  task automatic test_fault;
    for (int a = 0; a < 4; a++) begin
      act   = 2'(a);
      p_flt = 1'b1;
      wait_n(3);
      chk("fault action", {3'h1, a == 0, a == 1, a == 2}, {2'h0, ext_fault_reg,
          coast_stop_reg, emergency_stop_reg, decel_stop_reg});
      p_flt = 1'b0;
      wait_n(4);
    end
    // continue action: a running drive keeps its run command
    p_fwd = 1'b1;
    wait_n(3);
    p_fwd = 1'b0;
    p_flt = 1'b1;
    wait_n(4);
    chk("continue run", 6'h03, {4'h0, run_cmd_reg, ext_fault_reg});
    p_flt  = 1'b0;
    p_stop = 1'b1;
    wait_n(3);
    p_stop = 1'b0;
    wait_n(3);
  endtask

  // scene a makes every condition true but run forward and the two faults, scene b every one false but drive fault
  task automatic scene(input bit a);
    {pwr, en_used, en_in, wob} = 4'hf;
    dfault  = !a;
    {running, rev, dcb, torq, fd1, fd2} = {6{a}};
    f_out  = a ? 16'h0064 : 16'h0065;
    f_zero = 16'h0064;
    f_set  = a ? 16'h0069 : 16'h006f;
    f_wid  = 16'h0005;
    f_up   = a ? 16'h0069 : 16'h00c8;
    f_lo   = a ? 16'h0069 : 16'h006e;
    f_ctr  = a ? 16'h0064 : 16'h0096;
    f_amp  = 16'h000a;
  endtask

  // expected condition level of one code in one scene
  function automatic logic cond_exp(input logic [5:0] c, input bit a);
    if (a)
      return !(c inside {6'h00, 6'h03, 6'h14, 6'h1f, 6'h20});
    return c == 6'h1f;
  endfunction

  // all six outputs on the same code, polarity and board presence varied
  task automatic test_outputs;
    logic [5:0] msk;
    logic [5:0] ev;
    for (int s = 0; s < 2; s++) begin
      scene(s == 0);
      board = (s == 0);
      pol   = (s == 0) ? 6'h00 : 6'h3f;
      msk   = board ? 6'h3f : 6'h07;
      foreach (codes[i]) begin
        sel = codes[i];
        wait_n(1);
        ev  = ({6{cond_exp(codes[i], s == 0)}} ^ pol) & msk;
        ev  = (codes[i] == 6'h00) ? 6'h00 : ev;
        chk("output code", ev, outs);
      end
    end
  endtask

  // watchdog sized well beyond the roughly 120 cycles the tests need
  initial begin
    #20000;
    fails++;
    end_of_test;
  end

  // main sequence
  initial begin
    fails = 0;
    comparisons = 0;
    reset = 1'b1;
    {p_stop, p_fwd, p_rev, p_dir, p_flt} = 5'h00;
    mode = 2'h0;
    act  = dtio_pkg::FA_RESET;
    sel  = 6'h02;
    pol  = 6'h3f;
    board = 1'b1;
    scene(1'b1);
    wait_n(3);
    chk("outputs in reset", 6'h00, outs);
    reset = 1'b0;
    wait_n(2);
    test_mode1;
    test_mode2;
    test_fault;
    test_outputs;
    end_of_test;
  end
endmodule
